// ### design/dcf_pkg.sv
/*
  Shared constants, configuration layout and helper functions for the
  dual-clock FIFO controller.
  Assumes: every file refers to items here as dcf_pkg::name, with no import.
*/
package dcf_pkg;

  localparam int unsigned PTR_W    = 13;   // 12-bit bit address plus wrap bit
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned THR_W    = 12;
  localparam int unsigned DATA_W   = 18;
  localparam int unsigned SEL_W    = 3;
  localparam int unsigned WORDS    = 512;  // storage lanes of nine bits
  localparam int unsigned LANE_W   = 9;
  localparam int unsigned SYNC_CFG = 19;

  localparam logic [PTR_W-1:0] DEPTH_BITS = 13'h1000;
  localparam logic [PTR_W-1:0] PTR_ONE    = 13'h0001;
  localparam logic [PTR_W-1:0] PTR_ZERO   = 13'h0000;

  // Width select codes
  localparam logic [SEL_W-1:0] SEL_X1  = 3'h0;
  localparam logic [SEL_W-1:0] SEL_X2  = 3'h1;
  localparam logic [SEL_W-1:0] SEL_X4  = 3'h2;
  localparam logic [SEL_W-1:0] SEL_X9  = 3'h3;
  localparam logic [SEL_W-1:0] SEL_X18 = 3'h4;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ALMOST_FULL_FLAG  = 8'h04;
  localparam logic [7:0] OFS_ALMOST_EMPTY_FLAG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ST = 8'h10;
  localparam logic [7:0] OFS_IRQ_CL = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;

  // Control register fields
  localparam int unsigned CTRL_WSEL_LSB = 0;
  localparam int unsigned CTRL_RSEL_LSB = 3;
  localparam int unsigned CTRL_FULL_STOP    = 6;
  localparam int unsigned CTRL_EMPTY_STOP    = 7;

  // Status register fields
  localparam int unsigned ST_FULL  = 16;
  localparam int unsigned ST_ALMOST_FULL_FLAG = 17;

  // Interrupt bits
  localparam int unsigned IRQ_N        = 3;
  localparam int unsigned IRQ_FULL     = 0;
  localparam int unsigned IRQ_ALMOST_FULL_FLAG    = 1;
  localparam int unsigned IRQ_OVERFLOW = 2;

  localparam logic [THR_W-1:0] AF_RESET = 12'hfff;
  localparam logic [THR_W-1:0] AE_RESET = 12'h000;

  typedef struct packed {
    logic             empty_stop;
    logic             full_stop;
    logic [SEL_W-1:0] read_width_select;
    logic [SEL_W-1:0] write_width_select;
  } dcf_ctrl_t;

  typedef struct packed {
    logic [THR_W-1:0] almost_full_threshold;
    logic [THR_W-1:0] almost_empty_threshold;
    dcf_ctrl_t        ctrl;
  } dcf_cfg_t;

  // Bit-unit step per word is 1 << shift; nine and eighteen scale as 8, 16
  function automatic logic [2:0] width_shift(input logic [SEL_W-1:0] sel);
    unique case (sel)
      SEL_X1:  width_shift = 3'h0;
      SEL_X2:  width_shift = 3'h1;
      SEL_X4:  width_shift = 3'h2;
      SEL_X9:  width_shift = 3'h3;
      SEL_X18: width_shift = 3'h4;
      default: width_shift = 3'h0;
    endcase
  endfunction

  function automatic logic width_legal(input logic [SEL_W-1:0] sel);
    width_legal = (sel <= SEL_X18);
  endfunction

  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    for (int i = PTR_W - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PTR_W - 1) ? 1'b0 : b[i+1]);
    end
    gray2bin = b;
  endfunction

endpackage

// ### design/dcf_sync.sv
/*
  Two-flop level synchroniser of configurable width.
  Assumes: multi-bit inputs are Gray coded or held still while they cross.
*/
`timescale 1ns/1ps
module dcf_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// ### design/dcf_ram.sv
/*
  Storage array, 512 lanes of nine bits, addressed in bit units.
  Assumes: addresses are aligned to the word step of their width select.
  The array is never reset.
*/
`timescale 1ns/1ps
module dcf_ram (
  input  wire logic                            wclk_i,
  input  wire logic                            we_i,
  input  wire logic [dcf_pkg::ADDR_W-1:0]      write_pointer_i,
  input  wire logic [dcf_pkg::SEL_W-1:0]       wsel_i,
  input  wire logic [dcf_pkg::DATA_W-1:0]      wdata_i,
  input  wire logic                            rclk_i,
  input  wire logic                            rstn_i,
  input  wire logic                            re_i,
  input  wire logic [dcf_pkg::ADDR_W-1:0]      read_pointer_i,
  input  wire logic [dcf_pkg::SEL_W-1:0]       rsel_i,
  output logic      [dcf_pkg::DATA_W-1:0]      rdata_o
);

  logic [dcf_pkg::LANE_W-1:0] mem [dcf_pkg::WORDS];
  logic [dcf_pkg::ADDR_W-1:0] wu [4];
  logic [dcf_pkg::ADDR_W-1:0] ru [4];
  logic [dcf_pkg::DATA_W-1:0] rdata_d;
  logic [dcf_pkg::DATA_W-1:0] rdata_q;
  logic [2:0]                 wsh;
  logic [2:0]                 rsh;

  assign wsh = dcf_pkg::width_shift(wsel_i);
  assign rsh = dcf_pkg::width_shift(rsel_i);

  // Narrow shapes pack eight bits per lane; the ninth is left unused
  for (genvar k = 0; k < 4; k++) begin : g_unit
    assign wu[k] = write_pointer_i + dcf_pkg::ADDR_W'(k);
    assign ru[k] = read_pointer_i + dcf_pkg::ADDR_W'(k);
  end

  always_ff @(posedge wclk_i) begin
    if (we_i) begin
      if (wsh == 3'h3) begin
        mem[write_pointer_i[11:3]] <= wdata_i[8:0];
      end else if (wsh == 3'h4) begin
        mem[write_pointer_i[11:3]]         <= wdata_i[8:0];
        mem[write_pointer_i[11:3] + 9'h1]  <= wdata_i[17:9];
      end else begin
        for (int k = 0; k < 4; k++) begin
          if (k < (1 << wsh)) begin
            mem[wu[k][11:3]][wu[k][2:0]] <= wdata_i[k];
          end
        end
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    if (rsh == 3'h3) begin
      rdata_d[8:0] = mem[read_pointer_i[11:3]];
    end else if (rsh == 3'h4) begin
      rdata_d[8:0]  = mem[read_pointer_i[11:3]];
      rdata_d[17:9] = mem[read_pointer_i[11:3] + 9'h1];
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (k < (1 << rsh)) begin
          rdata_d[k] = mem[ru[k][11:3]][ru[k][2:0]];
        end
      end
    end
  end

  // Output hold register: keeps the last word until the next read
  always_ff @(posedge rclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= '0;
    end else if (re_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

endmodule

// ### design/dcf_fifo.sv
/*
  Dual-clock FIFO controller: bit-unit pointers, Gray crossing, flags,
  stop options, register port and interrupt.
  Assumes: write side and register port run on clk_i, read side on
  rd_clk_i; read-side settings are changed only while the FIFO is idle.
*/
// Our own choices: the address-and-strobe port and the register addresses.
// What this block does
// - Almost-empty and almost-full thresholds are twelve bits wide.
// - With empty stop, read counter holds at empty; otherwise keeps reading.
// - With full stop, write counter holds at full; otherwise keeps writing.
// - Counters run from zero to the shape's top location, then wrap.
// - Separate write and read pointers advance on each write and read.
// - Almost-full set while pointer difference is at least its threshold.
// - Almost-empty set while pointer difference is at most its threshold.
// - Thresholds count bit units, eight or sixteen per nine- or eighteen-bit word, not words.
// - Full or empty as soon as one whole word cannot move.
// - Port widths 1, 2, 4, 9, 18; depth 256 to 4096 words.
// - Three-bit width select per port; codes five to seven reserved.
// - Empty and full release two edges after the opposite side moves.
// - Reset clears control and hold registers, blocks transfers, keeps array.
`timescale 1ns/1ps
module dcf_fifo (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic [7:0]                 reg_addr_i,
  input  wire logic [31:0]                reg_wdata_i,
  input  wire logic                       reg_we_i,
  input  wire logic                       reg_re_i,
  output logic      [31:0]                reg_rdata_o,
  output logic                            irq_o,
  input  wire logic                       wr_en_i,
  input  wire logic [dcf_pkg::DATA_W-1:0] wr_data_i,
  output logic                            full_o,
  output logic                            almost_full_o,
  input  wire logic                       rd_clk_i,
  input  wire logic                       rd_en_i,
  output logic      [dcf_pkg::DATA_W-1:0] rd_data_o,
  output logic                            empty_o,
  output logic                            almost_empty_o
);

  // Register state, clk_i domain
  dcf_pkg::dcf_cfg_t             cfg_q, cfg_d;
  logic [dcf_pkg::IRQ_N-1:0]     irq_st_q, irq_st_d;
  logic [dcf_pkg::IRQ_N-1:0]     irq_en_q, irq_en_d;
  logic [31:0]                   rdata_q, rdata_d;

  // Write domain state
  logic [dcf_pkg::PTR_W-1:0]     write_pointer_q, write_pointer_d;
  logic [dcf_pkg::PTR_W-1:0]     wgray_q, wgray_d;
  logic                          full_prev_q, full_prev_d;
  logic                          almost_full_flag_prev_q, almost_full_flag_prev_d;

  // Read domain state
  logic [dcf_pkg::PTR_W-1:0]     read_pointer_q, read_pointer_d;
  logic [dcf_pkg::PTR_W-1:0]     rgray_q, rgray_d;

  // Crossing results
  logic [dcf_pkg::PTR_W-1:0]     rgray_w;
  logic [dcf_pkg::PTR_W-1:0]     wgray_r;
  dcf_pkg::dcf_cfg_t             cfg_r;

  // Write side combinational
  logic [2:0]                    wsh;
  logic [2:0]                    rsh_w;
  logic [dcf_pkg::PTR_W-1:0]     wstep;
  logic [dcf_pkg::PTR_W-1:0]     rptr_w;
  logic [dcf_pkg::PTR_W-1:0]     used_w;
  logic                          full_c;
  logic                          almost_full_flag_c;
  logic                          wr_go;

  // Read side combinational
  logic [2:0]                    rsh;
  logic [2:0]                    wsh_r;
  logic [dcf_pkg::PTR_W-1:0]     rstep;
  logic [dcf_pkg::PTR_W-1:0]     wptr_r;
  logic [dcf_pkg::PTR_W-1:0]     used_r;
  logic                          empty_c;
  logic                          almost_empty_flag_c;
  logic                          rd_go;

  logic [dcf_pkg::IRQ_N-1:0]     irq_set;

  // Write side: pointer in bit units, eight or sixteen per wide word
  always_comb begin
    wsh    = dcf_pkg::width_shift(cfg_q.ctrl.write_width_select);
    rsh_w  = dcf_pkg::width_shift(cfg_q.ctrl.read_width_select);
    wstep  = dcf_pkg::PTR_ONE << wsh;
    rptr_w = dcf_pkg::gray2bin(rgray_w) << rsh_w;
    used_w = write_pointer_q - rptr_w;
    // Full as soon as one whole write word no longer fits
    full_c  = (dcf_pkg::DEPTH_BITS - used_w) < wstep;
    almost_full_flag_c = used_w >= {1'b0, cfg_q.almost_full_threshold};
    // Reserved codes refuse transfers rather than guess a shape
    wr_go = wr_en_i
          && dcf_pkg::width_legal(cfg_q.ctrl.write_width_select)
          && !(full_c && cfg_q.ctrl.full_stop);
    write_pointer_d = wr_go ? write_pointer_q + wstep
                            : write_pointer_q;
    // Gray of the word count changes one bit per step, even for wide words
    wgray_d = dcf_pkg::bin2gray(write_pointer_d >> wsh);
    full_prev_d  = full_c;
    almost_full_flag_prev_d = almost_full_flag_c;
  end

  // Reset holds every pointer, so no transfer can start while it is low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      write_pointer_q <= dcf_pkg::PTR_ZERO;
      wgray_q         <= dcf_pkg::PTR_ZERO;
      full_prev_q     <= 1'b0;
      almost_full_flag_prev_q    <= 1'b0;
    end else begin
      write_pointer_q <= write_pointer_d;
      wgray_q         <= wgray_d;
      full_prev_q     <= full_prev_d;
      almost_full_flag_prev_q    <= almost_full_flag_prev_d;
    end
  end

  assign full_o        = full_c;
  assign almost_full_o = almost_full_flag_c;

  // Read side
  always_comb begin
    rsh    = dcf_pkg::width_shift(cfg_r.ctrl.read_width_select);
    wsh_r  = dcf_pkg::width_shift(cfg_r.ctrl.write_width_select);
    rstep  = dcf_pkg::PTR_ONE << rsh;
    wptr_r = dcf_pkg::gray2bin(wgray_r) << wsh_r;
    used_r = wptr_r - read_pointer_q;
    // Empty while less than one whole read word is stored
    empty_c  = used_r < rstep;
    almost_empty_flag_c = used_r <= {1'b0, cfg_r.almost_empty_threshold};
    // Without empty stop the counter runs on, replaying old content
    rd_go = rd_en_i
          && dcf_pkg::width_legal(cfg_r.ctrl.read_width_select)
          && !(empty_c && cfg_r.ctrl.empty_stop);
    read_pointer_d = rd_go ? read_pointer_q + rstep
                           : read_pointer_q;
    rgray_d = dcf_pkg::bin2gray(read_pointer_d >> rsh);
  end

  always_ff @(posedge rd_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      read_pointer_q <= dcf_pkg::PTR_ZERO;
      rgray_q        <= dcf_pkg::PTR_ZERO;
    end else begin
      read_pointer_q <= read_pointer_d;
      rgray_q        <= rgray_d;
    end
  end

  assign empty_o        = empty_c;
  assign almost_empty_o = almost_empty_flag_c;

  // Two flops each way: flags release on the second edge after a move
  dcf_sync #(
    .W(dcf_pkg::PTR_W)
  ) u_sync_r2w (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (rgray_q),
    .q_o    (rgray_w)
  );

  dcf_sync #(
    .W(dcf_pkg::PTR_W)
  ) u_sync_w2r (
    .clk_i  (rd_clk_i),
    .rstn_i (rstn_i),
    .d_i    (wgray_q),
    .q_o    (wgray_r)
  );

  // Settings are quasi-static; they must not change while data is moving
  dcf_sync #(
    .W(dcf_pkg::SYNC_CFG)
  ) u_sync_cfg (
    .clk_i  (rd_clk_i),
    .rstn_i (rstn_i),
    .d_i    ({cfg_q.almost_empty_threshold, cfg_q.ctrl.empty_stop,
              cfg_q.ctrl.read_width_select,
              cfg_q.ctrl.write_width_select}),
    .q_o    ({cfg_r.almost_empty_threshold, cfg_r.ctrl.empty_stop,
              cfg_r.ctrl.read_width_select,
              cfg_r.ctrl.write_width_select})
  );

  // Fields the read side never uses
  assign cfg_r.almost_full_threshold = '0;
  assign cfg_r.ctrl.full_stop        = 1'b0;

  dcf_ram u_ram (
    .wclk_i  (clk_i),
    .we_i    (wr_go),
    .write_pointer_i (write_pointer_q[dcf_pkg::ADDR_W-1:0]),
    .wsel_i  (cfg_q.ctrl.write_width_select),
    .wdata_i (wr_data_i),
    .rclk_i  (rd_clk_i),
    .rstn_i  (rstn_i),
    .re_i    (rd_go),
    .read_pointer_i (read_pointer_q[dcf_pkg::ADDR_W-1:0]),
    .rsel_i  (cfg_r.ctrl.read_width_select),
    .rdata_o (rd_data_o)
  );

  // Register port and interrupt
  always_comb begin
    irq_set = '0;
    irq_set[dcf_pkg::IRQ_FULL]     = full_c && !full_prev_q;
    irq_set[dcf_pkg::IRQ_ALMOST_FULL_FLAG]    = almost_full_flag_c && !almost_full_flag_prev_q;
    irq_set[dcf_pkg::IRQ_OVERFLOW] = wr_en_i && full_c;

    cfg_d    = cfg_q;
    irq_en_d = irq_en_q;
    irq_st_d = irq_st_q;
    if (reg_we_i) begin
      unique case (reg_addr_i)
        dcf_pkg::OFS_CTRL: begin
          cfg_d.ctrl.write_width_select =
            reg_wdata_i[dcf_pkg::CTRL_WSEL_LSB +: dcf_pkg::SEL_W];
          cfg_d.ctrl.read_width_select  =
            reg_wdata_i[dcf_pkg::CTRL_RSEL_LSB +: dcf_pkg::SEL_W];
          cfg_d.ctrl.full_stop  = reg_wdata_i[dcf_pkg::CTRL_FULL_STOP];
          cfg_d.ctrl.empty_stop = reg_wdata_i[dcf_pkg::CTRL_EMPTY_STOP];
        end
        dcf_pkg::OFS_ALMOST_FULL_FLAG:
          cfg_d.almost_full_threshold = reg_wdata_i[dcf_pkg::THR_W-1:0];
        dcf_pkg::OFS_ALMOST_EMPTY_FLAG:
          cfg_d.almost_empty_threshold = reg_wdata_i[dcf_pkg::THR_W-1:0];
        dcf_pkg::OFS_IRQ_CL:
          irq_st_d = irq_st_q & ~reg_wdata_i[dcf_pkg::IRQ_N-1:0];
        dcf_pkg::OFS_IRQ_EN:
          irq_en_d = reg_wdata_i[dcf_pkg::IRQ_N-1:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle
    irq_st_d = irq_st_d | irq_set;

    rdata_d = '0;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        dcf_pkg::OFS_CTRL:   rdata_d[7:0] = cfg_q.ctrl;
        dcf_pkg::OFS_ALMOST_FULL_FLAG:  rdata_d[11:0] = cfg_q.almost_full_threshold;
        dcf_pkg::OFS_ALMOST_EMPTY_FLAG: rdata_d[11:0] = cfg_q.almost_empty_threshold;
        dcf_pkg::OFS_STATUS: begin
          rdata_d[dcf_pkg::PTR_W-1:0] = used_w;
          rdata_d[dcf_pkg::ST_FULL]   = full_c;
          rdata_d[dcf_pkg::ST_ALMOST_FULL_FLAG]  = almost_full_flag_c;
        end
        dcf_pkg::OFS_IRQ_ST: rdata_d[dcf_pkg::IRQ_N-1:0] = irq_st_q;
        dcf_pkg::OFS_IRQ_EN: rdata_d[dcf_pkg::IRQ_N-1:0] = irq_en_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q.almost_full_threshold  <= dcf_pkg::AF_RESET;
      cfg_q.almost_empty_threshold <= dcf_pkg::AE_RESET;
      cfg_q.ctrl                   <= '0;
      irq_st_q                     <= '0;
      irq_en_q                     <= '0;
      rdata_q                      <= '0;
    end else begin
      cfg_q    <= cfg_d;
      irq_st_q <= irq_st_d;
      irq_en_q <= irq_en_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o       = |(irq_st_q & irq_en_q);

endmodule

// ### dv/dcf_fifo_assertions.sv
/*
  Port checker for the dual-clock FIFO controller.
  Assumes: bound to dcf_fifo; rstn_i low resets both clock domains.
*/
`timescale 1ns/1ps
module dcf_fifo_assertions (
  input wire logic                       clk_i,
  input wire logic                       rstn_i,
  input wire logic [7:0]                 reg_addr_i,
  input wire logic [31:0]                reg_wdata_i,
  input wire logic                       reg_we_i,
  input wire logic                       reg_re_i,
  input wire logic [31:0]                reg_rdata_o,
  input wire logic                       irq_o,
  input wire logic                       wr_en_i,
  input wire logic                       full_o,
  input wire logic                       almost_full_o,
  input wire logic                       rd_clk_i,
  input wire logic                       rd_en_i,
  input wire logic [dcf_pkg::DATA_W-1:0] rd_data_o,
  input wire logic                       empty_o
);
  sequence s_thr_wr;
    reg_we_i && reg_addr_i == dcf_pkg::OFS_ALMOST_FULL_FLAG;
  endsequence
  sequence s_thr_rd;
    reg_re_i && reg_addr_i == dcf_pkg::OFS_ALMOST_FULL_FLAG;
  endsequence
  sequence s_ovf;
    wr_en_i && full_o;
  endsequence
  sequence s_st_rd;
    reg_re_i && reg_addr_i == dcf_pkg::OFS_IRQ_ST;
  endsequence
  property p_thr_back;
    @(posedge clk_i) disable iff (!rstn_i)
      s_thr_wr ##2 s_thr_rd |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 32'hfff);
  endproperty
  a_thr_back: assert property (p_thr_back)
    else $error("threshold read back differs");
  property p_ovf;
    @(posedge clk_i) disable iff (!rstn_i)
      s_ovf ##2 s_st_rd |=> reg_rdata_o[dcf_pkg::IRQ_OVERFLOW];
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("write while full not flagged");
  property p_rdata_idle;
    @(posedge clk_i) disable iff (!rstn_i)
      !$past(reg_re_i) |-> reg_rdata_o == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");
  property p_irq_off;
    @(posedge clk_i) disable iff (!rstn_i)
      reg_we_i && reg_addr_i == dcf_pkg::OFS_IRQ_EN && reg_wdata_i[2:0] == 3'h0
      |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt high while masked");
  property p_full_rise;
    @(posedge clk_i) disable iff (!rstn_i) $rose(full_o) |-> $past(wr_en_i);
  endproperty
  a_full_rise: assert property (p_full_rise)
    else $error("full rose without a write");
  property p_af_rise;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(almost_full_o) |-> $past(wr_en_i) || $past(reg_we_i);
  endproperty
  a_af_rise: assert property (p_af_rise)
    else $error("almost full rose without cause");
  property p_empty_rise;
    @(posedge rd_clk_i) disable iff (!rstn_i) $rose(empty_o) |-> $past(rd_en_i);
  endproperty
  a_empty_rise: assert property (p_empty_rise)
    else $error("empty rose without a read");
  property p_rd_hold;
    @(posedge rd_clk_i) disable iff (!rstn_i) !rd_en_i |=> $stable(rd_data_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
endmodule

bind dcf_fifo dcf_fifo_assertions dcf_fifo_assertions_i (
  .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .wr_en_i(wr_en_i),
  .full_o(full_o), .almost_full_o(almost_full_o), .rd_clk_i(rd_clk_i),
  .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .empty_o(empty_o));

// ### dv/dcf_rd_user.sv
/*
  Read-side user logic: one-cycle read requests on its own clock.
  Assumes: the bench calls pop and judges the data that comes back.
*/
`timescale 1ns/1ps
module dcf_rd_user (
  input  wire logic rd_clk_i,
  output logic      rd_en_o
);
  initial rd_en_o = 1'b0;
  // Gap lets the reader be slow as well as prompt
  task automatic pop(input int gap);
    repeat (gap) @(posedge rd_clk_i);
    @(posedge rd_clk_i);
    rd_en_o <= 1'b1;
    @(posedge rd_clk_i);
    rd_en_o <= 1'b0;
  endtask
endmodule

// ### dv/tb_dcf_fifo.sv
/*
  Self-checking bench for the dual-clock FIFO controller.
  Assumes: design, checker and read-side model compiled before it.
*/
`timescale 1ns/1ps
module tb_dcf_fifo;
  logic        clk_i = 1'b0;
  logic        rd_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic        wr_en_i = 1'b0;
  logic [17:0] wr_data_i = 18'h0;
  logic        rd_en_i;
  logic [31:0] reg_rdata_o;
  logic        irq_o, full_o, almost_full_o, empty_o, almost_empty_o;
  logic [17:0] rd_data_o, mask, d, f;
  logic [31:0] r;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  integer      seed = 99145;
  int          s, n, step, words, wd, cnt, af, ae;
  int          q[$];

  dcf_fifo dcf_fifo_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .wr_en_i(wr_en_i),
    .wr_data_i(wr_data_i), .full_o(full_o), .almost_full_o(almost_full_o),
    .rd_clk_i(rd_clk_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .empty_o(empty_o), .almost_empty_o(almost_empty_o));
  dcf_rd_user dcf_rd_user_i (.rd_clk_i(rd_clk_i), .rd_en_o(rd_en_i));

  initial forever #25 clk_i = ~clk_i;
  // Half period of 17 against 25 keeps the two clocks drifting against each other
  initial forever #17 rd_clk_i = ~rd_clk_i;

  task final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      final_report;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task rw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  task rr(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask

  task wr(input logic [17:0] v);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    wr_data_i <= v;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask

  task hard_reset;
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk("reset", 32'h3, {9'h0, rd_data_o, irq_o, full_o, almost_full_o,
           empty_o, almost_empty_o});
    @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask

  initial begin
    for (s = 0; s < 5; s++) begin
      step = 1 << s;
      words = 4096 >> s;
      wd = (s == 3) ? 9 : (s == 4) ? 18 : step;
      mask = 18'((1 << wd) - 1);
      hard_reset();
      rw(dcf_pkg::OFS_CTRL, 32'((s << 3) | s | (s == 4 ? 8'h40 : 8'hc0)));
      af = ($unsigned($random(seed)) % words) * step;
      ae = ($unsigned($random(seed)) % words) * step;
      rw(dcf_pkg::OFS_ALMOST_FULL_FLAG, 32'(af));
      rr(dcf_pkg::OFS_ALMOST_FULL_FLAG, r);
      chk("af_thr", 32'(af), r);
      rw(dcf_pkg::OFS_ALMOST_EMPTY_FLAG, 32'(ae));
      rw(dcf_pkg::OFS_IRQ_EN, 32'h7);
      q.delete();
      for (n = 1; n <= words; n++) begin
        d = 18'($random(seed)) & mask;
        q.push_back(d);
        wr(d);
        #1 chk("full", 32'(n == words), {31'h0, full_o});
        chk("almost_full_flag", 32'(n * step >= af), {31'h0, almost_full_o});
      end
      wr(18'h0);
      rr(dcf_pkg::OFS_IRQ_ST, r);
      chk("irq_st", 32'h7, {29'h0, r[2:0]});
      chk("irq_on", 32'h1, {31'h0, irq_o});
      rw(dcf_pkg::OFS_IRQ_EN, 32'h0);
      #1 chk("irq_mask", 32'h0, {31'h0, irq_o});
      rw(dcf_pkg::OFS_IRQ_CL, 32'h7);
      rw(dcf_pkg::OFS_IRQ_EN, 32'h7);
      #1 chk("irq_clr", 32'h0, {31'h0, irq_o});
      // Fill seen by the write side is the whole array, in bit units
      rr(dcf_pkg::OFS_STATUS, r);
      chk("status", 32'h31000, r);
      rr(dcf_pkg::OFS_CTRL, r);
      chk("ctrl", 32'((s << 3) | s | (s == 4 ? 8'h40 : 8'hc0)), r);
      rr(8'h40, r);
      chk("unmapped", 32'h0, r);
      repeat (4) @(posedge rd_clk_i);
      cnt = words;
      f = 18'(q[0]);
      while (q.size() > 0) begin
        d = 18'(q.pop_front());
        dcf_rd_user_i.pop(cnt % 3);
        cnt--;
        #1 chk("rdata", {14'h0, d}, {14'h0, rd_data_o});
        chk("empty", 32'(cnt == 0), {31'h0, empty_o});
        chk("almost_empty_flag", 32'(cnt * step <= ae), {31'h0, almost_empty_o});
      end
      dcf_rd_user_i.pop(0);
      #1 chk("reread", {14'h0, (s == 4) ? f : d}, {14'h0, rd_data_o});
    end
    hard_reset();
    rw(dcf_pkg::OFS_CTRL, 32'h95);
    wr(18'h3);
    repeat (5) @(posedge rd_clk_i);
    #1 chk("rsvd", 32'h1, {31'h0, empty_o});
    rw(dcf_pkg::OFS_CTRL, 32'h91);
    wr(18'h1);
    repeat (5) @(posedge rd_clk_i);
    #1 chk("half", 32'h1, {31'h0, empty_o});
    wr(18'h2);
    @(posedge rd_clk_i);
    #1 chk("sync", 32'h1, {31'h0, empty_o});
    repeat (4) @(posedge rd_clk_i);
    #1 chk("fill", 32'h0, {31'h0, empty_o});
    dcf_rd_user_i.pop(0);
    #1 chk("mixed", 32'h9, {14'h0, rd_data_o});
    final_report;
  end
endmodule
